// [design/crp_pkg.sv]
/*
 crp_pkg: constants and carrier types for the cascaded RGB pixel receiver.
 Assumes a 125 MHz core clock; all counts are derived from times in ns.
*/
package crp_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // bit sampling point between short (0.3 us) and long (0.6 us) high pulses
    localparam int SAMPLE_TIME_NS = 450;
    localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset interval: low for more than 80 us
    localparam int RESET_TIME_NS = 80000;
    localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // regenerated output symbol: 0 -> 0.3 us high, 1 -> 0.6 us high, 0.904 us period
    // kept at the shortest legal symbol so forwarding keeps up with a fast sender
    localparam int OUT_ZERO_HIGH_NS = 300;
    localparam int OUT_ONE_HIGH_NS = 600;
    localparam int OUT_SYMBOL_NS = 904;
    localparam int OUT_ZERO_CYCLES = OUT_ZERO_HIGH_NS / CLK_PERIOD_NS;
    localparam int OUT_ONE_CYCLES = OUT_ONE_HIGH_NS / CLK_PERIOD_NS;
    localparam int OUT_SYMBOL_CYCLES = OUT_SYMBOL_NS / CLK_PERIOD_NS;
    // pwm period 4 ms
    localparam int PWM_PERIOD_NS = 4000000;
    localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PIXEL_BITS = 24;
    localparam int CHAN_BITS = 8;
    localparam logic [23:0] COLOUR_RESET = 24'h000000;

    typedef struct packed {
        logic [7:0] green;
        logic [7:0] red;
        logic [7:0] blue;
    } crp_colour_type;

    typedef enum logic [1:0] {
        CRP_IDLE,
        CRP_HIGH,
        CRP_LOW
    } crp_rx_type;
endpackage

// [design/crp_pixel.sv]
/*
 crp_pixel: receive-and-forward logic of one smart RGB pixel in a chain.
 Assumes serial inputs are asynchronous pins; single core clock at 125 MHz.
*/
// Operation
// - keep first 24 bits as own colour
// - forward later bits downstream
// - output low until forwarding begins
// - captured data frozen until reset interval
// - three pwm outputs, 4 ms period
// - low over 80 us latches colour
// - pwm duty unchanged until reset detected
// - after reset capture next 24 bits
// - bypass input takes over when primary silent
// - 256 levels per channel
// - forwarded bits regenerated from own timing
// - decode 800 kbit/s up to 1100 kHz
// - pwm outputs dark until first latch
// - return-to-zero symbols, high then low
`timescale 1ns/1ps
module crp_pixel #(
    parameter int RESET_COUNT = crp_pkg::RESET_CYCLES,
    parameter int PWM_COUNT = crp_pkg::PWM_PERIOD_CYCLES
) (
    input wire logic core_clk, // 125 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic serial_data_in, // serial line from upstream
    input wire logic bypass_data_in, // stream from two positions upstream
    output logic serial_data_out, // regenerated downstream line
    output logic red_pwm_out, // red channel pwm
    output logic green_pwm_out, // green channel pwm
    output logic blue_pwm_out // blue channel pwm
);
    logic rstMeta;
    logic rstSync;
    logic [1:0] dinSync;
    logic [1:0] bypSync;
    logic lineIn;
    logic linePrev;
    logic [$clog2(crp_pkg::RESET_CYCLES + 2)+1:0] lowCount;
    logic [$clog2(crp_pkg::RESET_CYCLES + 2)+1:0] dinIdle;
    logic useBypass;
    logic idleLong;
    logic [8:0] highCount;
    logic [4:0] bitCount;
    logic [23:0] shiftReg;
    logic captured;
    logic resetSeen;
    crp_pkg::crp_colour_type shown;
    logic lit;
    logic [31:0] pwmCount;
    logic bitValid;
    logic bitValue;
    logic lastOwnBit;
    logic next_red;
    logic next_green;
    logic next_blue;
    // two-entry buffer
    logic [1:0] slotBit;
    logic [1:0] slotFull;
    logic wrIdx;
    logic rdIdx;
    logic bufInValid;
    logic bufOutReady;
    logic bufPush;
    logic bufPop;
    logic bufInReady;
    logic bufOutValid;
    logic bufOutData;
    logic txBusy;
    logic txBit;
    logic [7:0] txCount;
    logic txTake;
    logic symbolEnd;
    logic next_serialOut;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            dinSync <= 2'h0;
            bypSync <= 2'h0;
        end else begin
            dinSync <= {dinSync[0], serial_data_in};
            bypSync <= {bypSync[0], bypass_data_in};
        end
    end

    // primary idle watch; bypass chosen while primary quiet past a reset interval
    assign idleLong = dinIdle >= ($bits(dinIdle))'(RESET_COUNT);

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            dinIdle <= '0;
        end else if (dinSync[1]) begin
            dinIdle <= '0;
        end else if (!idleLong) begin
            dinIdle <= dinIdle + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            useBypass <= 1'b0;
        end else if (dinSync[1]) begin
            useBypass <= 1'b0;
        end else if (idleLong && bypSync[1]) begin
            useBypass <= 1'b1;
        end
    end

    assign lineIn = useBypass ? bypSync[1] : dinSync[1];

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            linePrev <= 1'b0;
        end else begin
            linePrev <= lineIn;
        end
    end

    // high pulse width measured, bit decided at falling edge
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            highCount <= '0;
        end else if (lineIn && !linePrev) begin
            highCount <= 9'h001;
        end else if (lineIn && highCount != 9'h1FF) begin
            highCount <= highCount + 9'h001;
        end
    end

    assign bitValid = !lineIn && linePrev;
    assign bitValue = highCount >= 9'(crp_pkg::SAMPLE_CYCLES);

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            lowCount <= '0;
        end else if (lineIn) begin
            lowCount <= '0;
        end else if (lowCount <= ($bits(lowCount))'(RESET_COUNT)) begin
            lowCount <= lowCount + 1'b1;
        end
    end

    // one pulse when the low stretch passes the reset length
    assign resetSeen = !lineIn && lowCount == ($bits(lowCount))'(RESET_COUNT);

    // own bits captured, msb first, green red blue
    assign lastOwnBit = bitCount == 5'(crp_pkg::PIXEL_BITS - 1);

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            shiftReg <= crp_pkg::COLOUR_RESET;
        end else if (bitValid && !captured && !resetSeen) begin
            shiftReg <= {shiftReg[22:0], bitValue};
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            bitCount <= '0;
        end else if (resetSeen) begin
            bitCount <= '0;
        end else if (bitValid && !captured) begin
            if (lastOwnBit) begin
                bitCount <= '0;
            end else begin
                bitCount <= bitCount + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            captured <= 1'b0;
        end else if (resetSeen) begin
            captured <= 1'b0;
        end else if (bitValid && !captured && lastOwnBit) begin
            captured <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            shown <= crp_pkg::COLOUR_RESET;
            lit <= 1'b0;
        end else if (resetSeen && captured) begin
            shown <= shiftReg;
            lit <= 1'b1;
        end
    end

    // pwm counter, 256 levels per channel over the 4 ms period
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            pwmCount <= '0;
        end else if (pwmCount == 32'(PWM_COUNT - 1)) begin
            pwmCount <= '0;
        end else begin
            pwmCount <= pwmCount + 32'h00000001;
        end
    end

    function automatic logic pwm_on(input logic [7:0] level, input logic [31:0] count);
        logic [39:0] limit;
        limit = 40'(level) * 40'(PWM_COUNT);
        pwm_on = {count, 8'h00} < limit;
    endfunction

    // channels dark until the first latch
    always_comb begin
        next_red = 1'b0;
        next_green = 1'b0;
        next_blue = 1'b0;
        if (lit) begin
            next_red = pwm_on(shown.red, pwmCount);
            next_green = pwm_on(shown.green, pwmCount);
            next_blue = pwm_on(shown.blue, pwmCount);
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            red_pwm_out <= 1'b0;
            green_pwm_out <= 1'b0;
            blue_pwm_out <= 1'b0;
        end else begin
            red_pwm_out <= next_red;
            green_pwm_out <= next_green;
            blue_pwm_out <= next_blue;
        end
    end

    // forwarded bits queue, two slots; the transmitter runs back to back at the
    // shortest legal symbol, so a sender at the top rate cannot outrun it
    assign bufInValid = bitValid && captured;
    assign bufOutReady = !txBusy || symbolEnd;
    assign bufInReady = !slotFull[wrIdx];
    assign bufOutValid = slotFull[rdIdx];
    assign bufOutData = slotBit[rdIdx];
    assign bufPush = bufInValid && bufInReady;
    assign bufPop = bufOutValid && bufOutReady;
    assign txTake = bufPop;

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            slotBit <= 2'h0;
        end else if (bufPush) begin
            slotBit[wrIdx] <= bitValue;
        end
    end

    // push needs an empty slot and pop a full one, so they never meet
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            slotFull <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (bufPush && wrIdx == 1'(i)) begin
                    slotFull[i] <= 1'b1;
                end else if (bufPop && rdIdx == 1'(i)) begin
                    slotFull[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            wrIdx <= 1'b0;
        end else if (bufPush) begin
            wrIdx <= !wrIdx;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            rdIdx <= 1'b0;
        end else if (bufPop) begin
            rdIdx <= !rdIdx;
        end
    end

    assign symbolEnd = txCount == 8'(crp_pkg::OUT_SYMBOL_CYCLES - 1);

    // regenerated symbol: fixed high and low times from own clock
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            txBusy <= 1'b0;
        end else if (txTake) begin
            txBusy <= 1'b1;
        end else if (symbolEnd) begin
            txBusy <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            txCount <= '0;
        end else if (txTake) begin
            txCount <= '0;
        end else if (txBusy) begin
            txCount <= txCount + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            txBit <= 1'b0;
        end else if (txTake) begin
            txBit <= bufOutData;
        end
    end

    always_comb begin
        next_serialOut = 1'b0;
        if (txBusy && !symbolEnd) begin
            if (txBit) begin
                next_serialOut = txCount < 8'(crp_pkg::OUT_ONE_CYCLES - 1);
            end else begin
                next_serialOut = txCount < 8'(crp_pkg::OUT_ZERO_CYCLES - 1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            serial_data_out <= 1'b0;
        end else begin
            serial_data_out <= next_serialOut;
        end
    end
endmodule // crp_pixel

// [verification/crp_pixel_sva.sv]
/* crp_pixel_sva: port checker bound to crp_pixel.
   Assumes one clock and serial inputs idle low. */
`timescale 1ns/1ps
module crp_pixel_sva #(
    parameter int RESET_COUNT = 200,
    parameter int PWM_COUNT = 512
) (
    input wire logic core_clk, // clock
    input wire logic nrst, // reset
    input wire logic serial_data_in, // in
    input wire logic bypass_data_in, // bypass
    input wire logic serial_data_out, // out
    input wire logic red_pwm_out, // red
    input wire logic green_pwm_out, // green
    input wire logic blue_pwm_out // blue
);
    localparam int ZW = crp_pkg::OUT_ZERO_CYCLES;
    localparam int OW = crp_pkg::OUT_ONE_CYCLES;
    logic anyIn, lit;
    int lowCnt, bitCnt, hiCnt;
    assign anyIn = serial_data_in | bypass_data_in;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lowCnt <= 0;
            bitCnt <= 0;
            hiCnt <= 0;
            lit <= 1'b0;
        end else begin
            lowCnt <= anyIn ? 0 : lowCnt + 1;
            hiCnt <= serial_data_out ? hiCnt + 1 : 0;
            // frame closed a little before the design sees the gap
            if (lowCnt == RESET_COUNT - 4) begin
                bitCnt <= 0;
                lit <= lit | (bitCnt >= 24);
            end else begin
                bitCnt <= bitCnt + int'($fell(anyIn));
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_out_held_low: assert property (bitCnt < 25 |-> !serial_data_out)
        else $error("early out");
    a_fwd_start: assert property ($fell(anyIn) && bitCnt == 24
        |-> ##[1:12] $rose(serial_data_out)) else $error("no forward");
    a_gap_idle: assert property (lowCnt > 170 |-> !serial_data_out)
        else $error("out in gap");
    a_dark_start: assert property (!lit |-> !(red_pwm_out || green_pwm_out || blue_pwm_out))
        else $error("lit early");
    a_rz_low: assert property ($fell(serial_data_out) |-> !serial_data_out [*8])
        else $error("short low");
    a_rz_high: assert property ($rose(serial_data_out) |-> serial_data_out [*8])
        else $error("short high");
    a_sym_end: assert property ($rose(serial_data_out) |-> ##[30:80] !serial_data_out)
        else $error("long high");
    a_sym_width: assert property ($fell(serial_data_out)
        |-> hiCnt inside {[ZW - 2:ZW + 2], [OW - 2:OW + 2]}) else $error("bad width");
    c_fwd: cover property ($rose(serial_data_out));
    c_lit: cover property ($rose(lit));
    c_byp: cover property ($fell(bypass_data_in));
endmodule // crp_pixel_sva
bind crp_pixel crp_pixel_sva #(.RESET_COUNT(RESET_COUNT), .PWM_COUNT(PWM_COUNT)) sva_u (
    .core_clk(core_clk), .nrst(nrst), .serial_data_in(serial_data_in),
    .bypass_data_in(bypass_data_in), .serial_data_out(serial_data_out), .red_pwm_out(red_pwm_out),
    .green_pwm_out(green_pwm_out), .blue_pwm_out(blue_pwm_out));

// [verification/crp_host_model.sv]
/* crp_host_model: upstream sender on serial and bypass lines.
   Assumes the bench calls its tasks; lines idle low. */
`timescale 1ns/1ps
module crp_host_model #(
    parameter int RESET_COUNT = 200
) (
    input wire logic core_clk, // clock
    output logic dataLine, // serial line
    output logic bypassLine // bypass line
);
    initial {dataLine, bypassLine} = 2'h0;
    // high 0.3 or 0.6 us, then low to fill the period
    task automatic sym(input logic b, input int per, input logic byp);
        int hi;
        hi = b ? 75 : 38;
        @(posedge core_clk);
        #1 {dataLine, bypassLine} = {!byp, byp};
        repeat (hi) @(posedge core_clk);
        #1 {dataLine, bypassLine} = 2'h0;
        repeat (per - hi - 1) @(posedge core_clk);
    endtask
    task automatic gap();
        repeat (RESET_COUNT + 20) @(posedge core_clk);
    endtask
endmodule // crp_host_model

// [verification/tb_top.sv]
/* tb_top: self-checking bench for crp_pixel.
   Assumes crp_host_model drives both serial inputs. */
`timescale 1ns/1ps
module tb_top;
    localparam int RN = 200;
    localparam int PN = 512;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic dIn, bIn, dOut, red, green, blue;
    int n_errors = 0;
    int tests_run = 0;
    int hiRun = 0;
    logic [31:0] rnd = 32'hDFE69BBF;
    logic [23:0] fwdQ[$];
    crp_pkg::crp_colour_type colA, colB;
    always #4 core_clk = ~core_clk;
    crp_host_model #(.RESET_COUNT(RN)) host_u (.core_clk(core_clk), .dataLine(dIn),
        .bypassLine(bIn));
    crp_pixel #(.RESET_COUNT(RN), .PWM_COUNT(PN)) dut_u (.core_clk(core_clk), .nrst(nrst),
        .serial_data_in(dIn), .bypass_data_in(bIn), .serial_data_out(dOut),
        .red_pwm_out(red), .green_pwm_out(green), .blue_pwm_out(blue));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic frame(input logic [31:0] bits, input int n, input int per, input logic byp);
        for (int i = n - 1; i >= 0; i--) begin
            if (n - 1 - i >= 24) fwdQ.push_back(24'(bits[i]));
            host_u.sym(bits[i], per, byp);
        end
    endtask
    task automatic measure(input crp_pkg::crp_colour_type c);
        logic [23:0] g, r, b;
        {g, r, b} = '0;
        repeat (PN) begin
            @(posedge core_clk);
            g = g + green;
            r = r + red;
            b = b + blue;
        end
        check(g, 24'(c.green) * (PN / 256));
        check(r, 24'(c.red) * (PN / 256));
        check(b, 24'(c.blue) * (PN / 256));
    endtask
    // forwarded symbols decoded by high time
    always @(posedge core_clk) begin
        if (dOut === 1'b1) begin
            hiRun <= hiRun + 1;
        end else if (hiRun != 0) begin
            hiRun <= 0;
            check(24'(hiRun > 56), fwdQ.size() != 0 ? fwdQ.pop_front() : 24'hFFFFFF);
        end
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge core_clk);
        measure(24'h0);
        rnd = lfsr(rnd);
        colA = {8'hFF, 8'h00, rnd[7:0]};
        frame({colA, 4'hA}, 28, 156, 1'b0);
        host_u.gap();
        measure(colA);
        rnd = lfsr(rnd);
        colB = rnd[23:0];
        fork
            frame({colB, 2'h2}, 26, 113, 1'b0);
            begin
                repeat (600) @(posedge core_clk);
                measure(colA);
            end
        join
        host_u.gap();
        measure(colB);
        rnd = lfsr(rnd);
        frame(rnd, 10, 156, 1'b0);
        host_u.gap();
        measure(colB);
        rnd = lfsr(rnd);
        frame(rnd[31:8], 24, 156, 1'b1);
        host_u.gap();
        measure(rnd[31:8]);
        check(24'(fwdQ.size()), 24'h0);
        test_done();
    end
endmodule // tb_top
